/* core/clock_output_select_pkg.sv */
// Purpose: Shared constants for the clock output selection block
// Assumes: 32-bit register port, byte addresses in words of four
// Notes:   Mode codes are shared by the pin pattern and the mode fields
package clock_output_select_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	localparam int          DIV_W           = 8;
	localparam int          PIN_N           = 9;
	// Register byte offsets
	localparam logic [7:0]  CLK_CTRL_OFS    = 8'h00;
	localparam logic [7:0]  TRIG_CTRL_OFS   = 8'h04;
	localparam logic [7:0]  STATUS_OFS      = 8'h08;
	// Output control fields
	localparam int          REF_EN_BIT      = 0;
	localparam int          OVERRIDE_BIT    = 1;
	localparam int          OVR_FLAG_BIT    = 2;
	localparam int          C_MODE_LSB      = 4;
	localparam int          D_MODE_LSB      = 6;
	localparam logic [7:0]  CLK_CTRL_RST    = 8'h01;
	// Trigger output control fields
	localparam int          TRIG_EN_BIT     = 0;
	localparam int          TRIG_MODE_LSB   = 1;
	localparam int          TRIG_DIV_LSB    = 8;
	localparam logic [15:0] TRIG_CTRL_RST   = 16'h0100;
	localparam logic [1:0]  TRIG_MODE_TS    = 2'h3;
	// Auxiliary mode codes
	localparam logic [1:0]  AUX_OFF         = 2'h0;
	localparam logic [1:0]  AUX_REF         = 2'h1;
	localparam logic [1:0]  AUX_REF_DIV2    = 2'h2;
	localparam logic [1:0]  AUX_REF_DIV4    = 2'h3;
	localparam logic [7:0]  RATIO_1         = 8'h01;
	localparam logic [7:0]  RATIO_2         = 8'h02;
	localparam logic [7:0]  RATIO_4         = 8'h04;
	// Pin vector positions after synchronising
	localparam int          PIN_DIFF_REF    = 0;
	localparam int          PIN_SE_REF      = 1;
	localparam int          PIN_SE_SEL      = 2;
	localparam int          PIN_SYNTH_EN    = 3;
	localparam int          PIN_PD          = 4;
	localparam int          PIN_CFG0        = 5;
	localparam int          PIN_CFG1        = 6;
	localparam int          PIN_TS          = 7;
	localparam int          PIN_SER_CLK     = 8;
endpackage : clock_output_select_pkg

/* core/edge_clock_divider.sv */
// Purpose: Divide a sampled clock level by a programmable ratio
// Assumes: Source already synchronised to clk_in
// Notes:   Ratio 1 passes the source, ratio 0 holds the output low
`timescale 1ns/10ps
module edge_clock_divider (
	input  wire logic                                     clk_in,
	input  wire logic                                     rstn_in,
	input  wire logic                                     clk_en_in,
	input  wire logic                                     run_in,
	input  wire logic                                     src_in,
	input  wire logic [clock_output_select_pkg::DIV_W-1:0] ratio_in,
	output logic                                          div_out
);
	import clock_output_select_pkg::*;

	logic             prev_reg;
	logic [DIV_W-1:0] count_reg;
	logic             rise;

	assign rise = src_in & ~prev_reg;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			prev_reg <= 1'b0;
		end else if (clk_en_in) begin
			prev_reg <= src_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			count_reg <= '0;
		end else if (clk_en_in) begin
			// Clamp after a ratio cut so the count never sits out of range
			if (!run_in || ratio_in <= RATIO_1 || count_reg >= ratio_in) begin
				count_reg <= '0;
			end else if (rise) begin
				if (count_reg >= ratio_in - RATIO_1) begin
					count_reg <= '0;
				end else begin
					count_reg <= count_reg + RATIO_1;
				end
			end
		end
	end

	// High while the count is below half the ratio, rounded down
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			div_out <= 1'b0;
		end else if (clk_en_in) begin
			if (!run_in || ratio_in == '0) begin
				div_out <= 1'b0;
			end else if (ratio_in == RATIO_1) begin
				div_out <= src_in;
			end else begin
				div_out <= (count_reg < (ratio_in >> 1));
			end
		end
	end

	property p_count_bound;
		@(posedge clk_in) disable iff (!rstn_in)
		run_in && ratio_in > RATIO_1 && $stable(ratio_in) && $past(clk_en_in)
			|-> count_reg < ratio_in;
	endproperty
	a_count_bound: assert property (p_count_bound) else $error("divider count out of range");

	property p_stop_low;
		@(posedge clk_in) disable iff (!rstn_in)
		clk_en_in && !run_in |=> !div_out;
	endproperty
	a_stop_low: assert property (p_stop_low) else $error("stopped divider drives high");
endmodule : edge_clock_divider

/* core/clock_output_select.sv */
// Purpose: Reference repeater, trigger clock and auxiliary clock outputs
// Assumes: Pin inputs asynchronous; over-range flag on clk_in
// Notes:   Clock pins are sampled, so output edges are clk_in quantised
// Notes on behaviour
// - Repeater carries the reference chosen by the single-ended select pin.
// - Repeater on by default with the synthesizer; software writing 0 stops it.
// - Repeater only with synthesizer pin high and power-down low.
// - Trigger output from timestamp input or serializer clock, by mode.
// - Trigger output off after reset until software enables it.
// - Serializer source is divided by the programmed divider.
// - Auxiliary outputs live from reset per pins; power-down stops both.
// - Override set: pins ignored, mode fields steer both auxiliary outputs.
// - Pins set enable and ratio for C, only enable for D.
// - Divided reference wins over the over-range flag on a pin.
// - D clock only while C mode is nonzero.
// - Pin codes for C: off or flag, reference, half, quarter.
// - Mode field codes for C: off or flag, reference, half, quarter.
// - Pins for D: any nonzero pattern gives plain reference.
`timescale 1ns/10ps
module clock_output_select #(
	parameter bit QUAD_VARIANT = 1'b1
) (
	input  wire logic                                      clk_in,
	input  wire logic                                      rstn_in,
	input  wire logic                                      clk_en_in,
	input  wire logic [clock_output_select_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [clock_output_select_pkg::DATA_W-1:0] wdata_in,
	input  wire logic                                      wr_in,
	input  wire logic                                      rd_in,
	output logic      [clock_output_select_pkg::DATA_W-1:0] rdata_out,
	input  wire logic                                      diff_ref_in,
	input  wire logic                                      single_ended_ref_in,
	input  wire logic                                      ref_single_ended_select_in,
	input  wire logic                                      synth_enable_pin_in,
	input  wire logic                                      power_down_pin_in,
	input  wire logic [1:0]                                clk_cfg_pins_in,
	input  wire logic                                      timestamp_in,
	input  wire logic                                      serdes_clk_in,
	input  wire logic                                      overrange_c_in,
	output logic                                           ref_repeat_out,
	output logic                                           trigger_clk_out,
	output logic                                           aux_out_c,
	output logic                                           aux_out_d
);
	import clock_output_select_pkg::*;

	logic [PIN_N-1:0] pin_raw;
	logic [PIN_N-1:0] pin_sync;
	logic [7:0]       clk_ctrl_reg;
	logic [15:0]      trig_ctrl_reg;
	logic             ref_sel;
	logic             pd_s;
	logic             ref_on;
	logic             override;
	logic             overrange_flag_enable;
	logic [1:0]       cfg_s;
	logic [1:0]       c_code;
	logic [1:0]       d_code;
	logic [DIV_W-1:0] c_ratio;
	logic [DIV_W-1:0] d_ratio;
	logic             c_div;
	logic             d_div;
	logic             trig_en;
	logic [1:0]       trig_mode;
	logic             trig_active;
	logic             trig_div;
	logic             flag_ok;
	logic [7:0]       status_word;

	assign pin_raw = {serdes_clk_in, timestamp_in, clk_cfg_pins_in,
		power_down_pin_in, synth_enable_pin_in,
		ref_single_ended_select_in, single_ended_ref_in, diff_ref_in};

	// Every pin crosses two flops before use
	genvar gi;
	generate
		for (gi = 0; gi < PIN_N; gi++) begin : g_sync
			logic s1_reg;
			logic s2_reg;
			always_ff @(posedge clk_in) begin
				if (!rstn_in) begin
					s1_reg <= 1'b0;
					s2_reg <= 1'b0;
				end else if (clk_en_in) begin
					s1_reg <= pin_raw[gi];
					s2_reg <= s1_reg;
				end
			end
			assign pin_sync[gi] = s2_reg;
		end
	endgenerate

	function automatic logic [DIV_W-1:0] code_ratio(input logic [1:0] code);
		logic [DIV_W-1:0] r;
		r = '0;
		unique case (code)
			AUX_OFF:      r = '0;
			AUX_REF:      r = RATIO_1;
			AUX_REF_DIV2: r = RATIO_2;
			AUX_REF_DIV4: r = RATIO_4;
		endcase
		return r;
	endfunction : code_ratio

	// Register writes
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			clk_ctrl_reg <= CLK_CTRL_RST;
		end else if (clk_en_in && wr_in && addr_in == CLK_CTRL_OFS) begin
			clk_ctrl_reg <= wdata_in[7:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			trig_ctrl_reg <= TRIG_CTRL_RST;
		end else if (clk_en_in && wr_in && addr_in == TRIG_CTRL_OFS) begin
			trig_ctrl_reg <= {wdata_in[15:8], 5'h00, wdata_in[2:0]};
		end
	end

	assign status_word = {cfg_s, pin_sync[PIN_SYNTH_EN], pd_s,
		c_code != AUX_OFF && d_code != AUX_OFF, c_code != AUX_OFF,
		trig_active, ref_on};

	// Read data for one cycle only, zero elsewhere
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			rdata_out <= '0;
		end else if (clk_en_in) begin
			rdata_out <= '0;
			if (rd_in) begin
				unique case (addr_in)
					CLK_CTRL_OFS:  rdata_out <= {24'h00_0000, clk_ctrl_reg};
					TRIG_CTRL_OFS: rdata_out <= {16'h0000, trig_ctrl_reg};
					STATUS_OFS:    rdata_out <= {24'h00_0000, status_word};
					default:       rdata_out <= '0;
				endcase
			end
		end
	end

	assign pd_s      = pin_sync[PIN_PD];
	assign cfg_s     = {pin_sync[PIN_CFG1], pin_sync[PIN_CFG0]};
	assign override  = clk_ctrl_reg[OVERRIDE_BIT];
	assign overrange_flag_enable    = clk_ctrl_reg[OVR_FLAG_BIT];
	assign flag_ok   = overrange_flag_enable && QUAD_VARIANT;
	assign trig_en   = trig_ctrl_reg[TRIG_EN_BIT];
	assign trig_mode = trig_ctrl_reg[TRIG_MODE_LSB +: 2];

	// Reference straight from the chosen input
	assign ref_sel = pin_sync[PIN_SE_SEL] ? pin_sync[PIN_SE_REF] : pin_sync[PIN_DIFF_REF];

	assign ref_on = clk_ctrl_reg[REF_EN_BIT] && pin_sync[PIN_SYNTH_EN] && !pd_s;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			ref_repeat_out <= 1'b0;
		end else if (clk_en_in) begin
			ref_repeat_out <= ref_on && ref_sel;
		end
	end

	// Output C code from pins or field
	assign c_code = override ? clk_ctrl_reg[C_MODE_LSB +: 2] : cfg_s;

	// Output D code, gated by C
	always_comb begin
		d_code = AUX_OFF;
		if (c_code != AUX_OFF) begin
			if (override) begin
				d_code = clk_ctrl_reg[D_MODE_LSB +: 2];
			end else if (cfg_s != AUX_OFF) begin
				d_code = AUX_REF;
			end
		end
	end

	assign c_ratio = code_ratio(c_code);
	assign d_ratio = code_ratio(d_code);

	edge_clock_divider u_div_c (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.clk_en_in (clk_en_in),
		.run_in    (!pd_s),
		.src_in    (ref_sel),
		.ratio_in  (c_ratio),
		.div_out   (c_div)
	);

	edge_clock_divider u_div_d (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.clk_en_in (clk_en_in),
		.run_in    (!pd_s),
		.src_in    (ref_sel),
		.ratio_in  (d_ratio),
		.div_out   (d_div)
	);

	// Clock beats flag, power-down stops both
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			aux_out_c <= 1'b0;
			aux_out_d <= 1'b0;
		end else if (clk_en_in) begin
			if (pd_s) begin
				aux_out_c <= 1'b0;
				aux_out_d <= 1'b0;
			end else begin
				aux_out_c <= (c_code != AUX_OFF) ? c_div : (flag_ok && overrange_c_in);
				// Flag on D follows channel C as printed
				aux_out_d <= (d_code != AUX_OFF) ? d_div : (flag_ok && overrange_c_in);
			end
		end
	end

	assign trig_active = trig_en && !pd_s;

	edge_clock_divider u_div_trig (
		.clk_in    (clk_in),
		.rstn_in   (rstn_in),
		.clk_en_in (clk_en_in),
		.run_in    (trig_active && trig_mode != TRIG_MODE_TS),
		.src_in    (pin_sync[PIN_SER_CLK]),
		.ratio_in  (trig_ctrl_reg[TRIG_DIV_LSB +: DIV_W]),
		.div_out   (trig_div)
	);

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			trigger_clk_out <= 1'b0;
		end else if (clk_en_in) begin
			if (!trig_active) begin
				trigger_clk_out <= 1'b0;
			end else if (trig_mode == TRIG_MODE_TS) begin
				trigger_clk_out <= pin_sync[PIN_TS];
			end else begin
				trigger_clk_out <= trig_div;
			end
		end
	end

	property p_ref_select;
		@(posedge clk_in) disable iff (!rstn_in)
		clk_en_in && ref_on && pin_sync[PIN_SE_SEL] |=> ref_repeat_out == $past(pin_sync[PIN_SE_REF]);
	endproperty
	a_ref_select: assert property (p_ref_select) else $error("repeater not on single-ended ref");

	property p_ref_sw_off;
		@(posedge clk_in) disable iff (!rstn_in)
		clk_en_in && wr_in && addr_in == CLK_CTRL_OFS && !wdata_in[REF_EN_BIT]
			##1 clk_en_in |=> !ref_repeat_out;
	endproperty
	a_ref_sw_off: assert property (p_ref_sw_off) else $error("repeater on after disable");

	property p_ref_pd;
		@(posedge clk_in) disable iff (!rstn_in)
		clk_en_in && (pd_s || !pin_sync[PIN_SYNTH_EN]) |=> !ref_repeat_out;
	endproperty
	a_ref_pd: assert property (p_ref_pd) else $error("repeater on without synth or in power-down");

	property p_trig_ts;
		@(posedge clk_in) disable iff (!rstn_in)
		clk_en_in && trig_active && trig_mode == TRIG_MODE_TS |=> trigger_clk_out == $past(pin_sync[PIN_TS]);
	endproperty
	a_trig_ts: assert property (p_trig_ts) else $error("trigger not repeating timestamp");

	property p_trig_off;
		@(posedge clk_in) disable iff (!rstn_in)
		clk_en_in && !trig_en |=> !trigger_clk_out;
	endproperty
	a_trig_off: assert property (p_trig_off) else $error("trigger active while disabled");

	property p_aux_pd;
		@(posedge clk_in) disable iff (!rstn_in)
		clk_en_in && pd_s |=> !aux_out_c && !aux_out_d;
	endproperty
	a_aux_pd: assert property (p_aux_pd) else $error("aux output active in power-down");

	property p_d_needs_c;
		@(posedge clk_in) disable iff (!rstn_in)
		clk_en_in && c_code == AUX_OFF && !overrange_flag_enable |=> !aux_out_d;
	endproperty
	a_d_needs_c: assert property (p_d_needs_c) else $error("D clock without C clock");

	property p_c_flag;
		@(posedge clk_in) disable iff (!rstn_in)
		clk_en_in && !pd_s && !override && cfg_s == AUX_OFF && flag_ok
			|=> aux_out_c == $past(overrange_c_in);
	endproperty
	a_c_flag: assert property (p_c_flag) else $error("C not showing over-range flag");

	property p_c_field;
		@(posedge clk_in) disable iff (!rstn_in)
		clk_en_in && !pd_s && override && clk_ctrl_reg[C_MODE_LSB +: 2] == AUX_OFF && !flag_ok
			|=> !aux_out_c;
	endproperty
	a_c_field: assert property (p_c_field) else $error("C not off from mode field");

	property p_d_pins;
		@(posedge clk_in) disable iff (!rstn_in)
		!override && cfg_s != AUX_OFF |-> d_ratio == RATIO_1;
	endproperty
	a_d_pins: assert property (p_d_pins) else $error("D pin mode not plain reference");
endmodule : clock_output_select

/* verif/clock_sink_model.sv */
// Purpose: Far-side receiver that counts rising edges of one clock output
// Assumes: Watched line is already in the clk_in domain
// Notes:   Counts only; the bench judges frequency from a fixed window
`timescale 1ns/10ps
module clock_sink_model (
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic        clear_in,
	input  wire logic        watch_in,
	output logic      [15:0] edges_out
);
	logic prev_reg;

	always_ff @(posedge clk_in) begin
		if (!rstn_in || clear_in) begin
			edges_out <= 16'h0000;
		end else if (watch_in && !prev_reg) begin
			edges_out <= edges_out + 16'h0001;
		end
	end

	always_ff @(posedge clk_in) begin
		prev_reg <= rstn_in ? watch_in : 1'b0;
	end
endmodule : clock_sink_model

/* verif/testbench.sv */
// Purpose: Self-checking bench for the clock output selection block
// Assumes: Reference periods of 8 and 16 cycles, serializer period 4
// Notes:   Edge counts over a window allow one edge of phase slack
`timescale 1ns/10ps
module testbench;
	import clock_output_select_pkg::*;
	localparam int WIN   = 256;
	localparam int LIMIT = 60000;
	logic        clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic        en_in = 1'b1;
	logic [7:0]  addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0000_0000;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic        diff_ref_in = 1'b0;
	logic        se_ref_in = 1'b0;
	logic        se_sel_in = 1'b0;
	logic        synth_in = 1'b1;
	logic        pd_in = 1'b0;
	logic [1:0]  cfg_in = 2'h0;
	logic        ts_in = 1'b0;
	logic        ser_in = 1'b0;
	logic        ovr_in = 1'b0;
	logic [3:0]  outs;
	logic        clear = 1'b0;
	logic [15:0] edges [4];
	logic [7:0]  cyc = 8'h00;
	int          bad_count = 0;
	int          n_checks = 0;
	int          cycles = 0;

	always #4 clk_in = ~clk_in;

	// Free-running stimulus clocks, changed just after the edge
	always @(posedge clk_in) begin
		cyc         <= cyc + 8'h01;
		diff_ref_in <= cyc[2];
		se_ref_in   <= cyc[3];
		ser_in      <= cyc[1];
	end

	clock_output_select u_dut (
		.clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(en_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.diff_ref_in(diff_ref_in), .single_ended_ref_in(se_ref_in),
		.ref_single_ended_select_in(se_sel_in), .synth_enable_pin_in(synth_in),
		.power_down_pin_in(pd_in), .clk_cfg_pins_in(cfg_in), .timestamp_in(ts_in),
		.serdes_clk_in(ser_in), .overrange_c_in(ovr_in), .ref_repeat_out(outs[0]),
		.trigger_clk_out(outs[1]), .aux_out_c(outs[2]), .aux_out_d(outs[3])
	);

	for (genvar g = 0; g < 4; g++) begin : g_sink
		clock_sink_model u_sink (
			.clk_in(clk_in), .rstn_in(rstn_in), .clear_in(clear),
			.watch_in(outs[g]), .edges_out(edges[g])
		);
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr_in    <= 1'b1;
		addr_in  <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_in);
		rd_in   <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in   <= 1'b0;
		#1;
		chk(rdata_out, exp);
	endtask : rd

	// Expected edges in one window; negative means not judged
	task automatic meas(input int e0, input int e1, input int e2, input int e3);
		int e [4];
		e = '{e0, e1, e2, e3};
		repeat (8) @(posedge clk_in);
		clear <= 1'b1;
		@(posedge clk_in);
		clear <= 1'b0;
		repeat (WIN) @(posedge clk_in);
		#1;
		for (int i = 0; i < 4; i++) begin
			if (e[i] >= 0) begin
				n_checks++;
				if (int'(edges[i]) > e[i] + 1 || int'(edges[i]) + 1 < e[i]) begin
					bad_count++;
					$display("unexpected at %0t: out %0d edges %0d want %0d",
						$time, i, edges[i], e[i]);
				end
			end
		end
	endtask : meas

	function automatic int edg(input int code);
		return (code == 0) ? 0 : (32 >> (code - 1));
	endfunction : edg

	task automatic levels(input logic [3:0] exp);
		repeat (6) @(posedge clk_in);
		#1;
		chk({28'h0, outs}, {28'h0, exp});
	endtask : levels

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == LIMIT) begin
			bad_count++;
			$display("unexpected at %0t: run did not finish", $time);
			complete_run();
		end
	end

	initial begin
		repeat (16) @(posedge clk_in);
		rstn_in <= 1'b1;
		rd(TRIG_CTRL_OFS, 32'h0000_0100);
		rd(CLK_CTRL_OFS, 32'h0000_0001);
		rd(STATUS_OFS, 32'h0000_0021);
		rd(8'h0c, 32'h0000_0000);
		meas(32, 0, 0, 0);
		se_sel_in <= 1'b1;
		meas(16, -1, -1, -1);
		se_sel_in <= 1'b0;
		wr(CLK_CTRL_OFS, 32'h0000_0000);
		meas(0, -1, -1, -1);
		wr(CLK_CTRL_OFS, 32'h0000_0001);
		synth_in <= 1'b0;
		meas(0, -1, -1, -1);
		synth_in <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			cfg_in <= k[1:0];
			meas(-1, -1, edg(k), (k == 0) ? 0 : 32);
		end
		// Repeater off so the sampled levels do not hang on reference phase
		ovr_in <= 1'b1;
		wr(CLK_CTRL_OFS, 32'h0000_0004);
		cfg_in <= 2'h0;
		levels(4'b1100);
		cfg_in <= 2'h1;
		meas(-1, -1, 32, 32);
		cfg_in <= 2'h3;
		for (int c = 0; c < 4; c++) begin
			for (int d = 0; d < 4; d++) begin
				wr(CLK_CTRL_OFS, 32'h0000_0003 | (c << 4) | (d << 6));
				meas(-1, -1, edg(c), (c == 0) ? 0 : edg(d));
			end
		end
		wr(CLK_CTRL_OFS, 32'h0000_00c6);
		levels(4'b1100);
		wr(TRIG_CTRL_OFS, 32'h0000_0401);
		meas(-1, 16, -1, -1);
		wr(TRIG_CTRL_OFS, 32'h0000_0101);
		meas(-1, 64, -1, -1);
		wr(TRIG_CTRL_OFS, 32'h0000_0107);
		ts_in <= 1'b1;
		levels(4'b1110);
		// Clock enable low must freeze every output
		en_in <= 1'b0;
		ts_in <= 1'b0;
		levels(4'b1110);
		en_in <= 1'b1;
		levels(4'b1100);
		wr(TRIG_CTRL_OFS, 32'h0000_0101);
		wr(CLK_CTRL_OFS, 32'h0000_0001);
		cfg_in <= 2'h1;
		pd_in  <= 1'b1;
		meas(0, 0, 0, 0);
		rd(STATUS_OFS, 32'h0000_007c);
		complete_run();
	end
endmodule : testbench
